// ==== shared/ipx_pkg.sv ====
// constants, types and register map of the interrupt priority exception unit
// How it works
// - with machine-check enable set, bus-check request outranks every external source
// - maskable request is lowest among ordinary external inputs
// - stop-clock request ranks below everything, maskable included (75 MHz parts)
// - once machine-check handler starts, other external requests are blocked
// - machine check, flush/smi, debug and io restart pending: machine check first, never invalid opcode
// - task switch loading a trap bit raises debug vector 1 after the switch
// - debug handler in not-present segment escalates to vector 11, consistent cs and ip
// - verify and access-rights instructions take their page faults normally, even to a task
// - debug exception sets hit bit of every matching breakpoint, enabled or not
// - matched flags latched in temp, copied to debug status even across stop-clock
// - io restart smi saves ip of the triggering io instruction, not a handler's entry
package ipx_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] IPX_CTRL_OFS     = 8'h00;
   localparam logic [7:0] IPX_DSTAT_OFS    = 8'h04;
   localparam logic [7:0] IPX_SVC_OFS      = 8'h08;
   localparam logic [7:0] IPX_SAVEIP_OFS   = 8'h0C;
   localparam logic [7:0] IPX_IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IPX_IRQ_EN_OFS   = 8'h14;
   localparam logic [7:0] IPX_IRQ_CLR_OFS  = 8'h18;
   localparam logic [7:0] IPX_STATUS_OFS   = 8'h1C;

   // control register fields
   localparam int CTRL_MCE_BIT     = 0;
   localparam int CTRL_IORST_BIT   = 1;
   localparam int CTRL_IF_BIT      = 2;
   localparam int CTRL_MC_DONE_BIT = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // vectors
   localparam logic [7:0] VEC_DEBUG   = 8'h01;
   localparam logic [7:0] VEC_NMI     = 8'h02;
   localparam logic [7:0] VEC_NOTPRES = 8'h0B;
   localparam logic [7:0] VEC_PAGEF   = 8'h0E;
   localparam logic [7:0] VEC_MCHECK  = 8'h12;
   localparam logic [7:0] VEC_NONE    = 8'hFF;

   // interrupt status bits
   localparam int IRQ_BITS      = 4;
   localparam int IRQB_MCHECK   = 0;
   localparam int IRQB_DEBUG    = 1;
   localparam int IRQB_SMI      = 2;
   localparam int IRQB_STOPCLK  = 3;

   localparam int NUM_BP = 4;

   typedef enum logic [3:0] {
      SRC_NONE, SRC_MCHECK, SRC_FLUSH, SRC_SMI, SRC_NMI,
      SRC_DEBUG, SRC_PAGEF, SRC_MASKABLE_IRQ_REQUEST, SRC_STOPCLK
   } ipx_src_t;

   typedef enum logic [1:0] { ST_RUN, ST_ENTER, ST_MC_HANDLER } ipx_state_t;

endpackage : ipx_pkg

// ==== hw/ipx_sync2.sv ====
// two-flop synchroniser for a group of pin inputs
module ipx_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= INIT;
         q_out  <= INIT;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule : ipx_sync2

// ==== hw/ipx_unit.sv ====
// interrupt priority and exception arbitration with apb registers
module ipx_unit
   import ipx_pkg::*;
(
   input  wire logic              CLK_SYS_IN,
   input  wire logic              RESET_IN,
   // external request pins
   input  wire logic              BUS_CHECK_REQUEST_N_IN,
   input  wire logic              FLUSH_REQUEST_N_IN,
   input  wire logic              SYSTEM_MGMT_IRQ_N_IN,
   input  wire logic              NMI_REQUEST_IN,
   input  wire logic              MASKABLE_IRQ_REQUEST_IN,
   input  wire logic              STOP_CLOCK_REQUEST_N_IN,
   // core-side events
   input  wire logic              INSN_BOUNDARY_IN,
   input  wire logic [31:0]       CUR_IP_IN,
   input  wire logic              IO_RESTART_EVENT_IN,
   input  wire logic              SINGLE_STEP_IN,
   input  wire logic              TASK_SWITCH_DONE_IN,
   input  wire logic              TSS_TRAP_BIT_IN,
   input  wire logic              DEBUG_SEG_PRESENT_IN,
   input  wire logic              VERIFY_PAGE_FAULT_IN,
   input  wire logic [NUM_BP-1:0] BP_MATCH_IN,
   // apb
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // service outputs
   output logic                   SERVICE_VALID_OUT,
   output logic      [7:0]        SERVICE_VECTOR_OUT,
   output logic      [3:0]        SERVICE_SOURCE_OUT,
   output logic                   IRQ_OUT
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [5:0] pins_s;
   // reset value is the idle level of every pin, so no request shows while the flops fill
   ipx_sync2 #(.WIDTH(6), .INIT(6'h27)) u_sync (
      .clk_in (CLK_SYS_IN),
      .rst_in (RESET_IN),
      .d_in   ({STOP_CLOCK_REQUEST_N_IN, MASKABLE_IRQ_REQUEST_IN, NMI_REQUEST_IN,
                SYSTEM_MGMT_IRQ_N_IN, FLUSH_REQUEST_N_IN, BUS_CHECK_REQUEST_N_IN}),
      .q_out  (pins_s)
   );
   wire bus_check_s  = ~pins_s[0];
   wire flush_s      = ~pins_s[1];
   wire smi_s        = ~pins_s[2];
   wire nmi_s        = pins_s[3];
   wire maskable_irq_request_s       = pins_s[4];
   wire stopclk_s    = ~pins_s[5];

   // ****************************************
   // registers and state
   // ****************************************
   logic [31:0]       ctrl_q;
   logic [NUM_BP-1:0] bp_temp_q, dstat_q;
   logic              dbg_pend_q, bp_pend_q, mc_pend_q, pf_pend_q;
   logic [31:0]       io_ip_q, save_ip_q;
   logic              io_ip_vld_q;
   logic [IRQ_BITS-1:0] irq_stat_q, irq_en_q;
   ipx_state_t        state_q;
   ipx_src_t          src_q;

   wire mce_en    = ctrl_q[CTRL_MCE_BIT];
   wire io_rst_en = ctrl_q[CTRL_IORST_BIT];
   wire if_en     = ctrl_q[CTRL_IF_BIT];
   wire mc_block  = (state_q == ST_MC_HANDLER);

   // debug exception raised by step, breakpoint or trapped task switch
   wire dbg_raise = SINGLE_STEP_IN | (|BP_MATCH_IN) |
                    (TASK_SWITCH_DONE_IN & TSS_TRAP_BIT_IN);

   // ****************************************
   // fixed priority selection
   // ****************************************
   function automatic ipx_src_t pick(input logic mc, input logic fl, input logic sm,
                                     input logic nm, input logic db, input logic pf,
                                     input logic it, input logic sc);
      if (mc)      pick = SRC_MCHECK;
      else if (fl) pick = SRC_FLUSH;
      else if (sm) pick = SRC_SMI;
      else if (nm) pick = SRC_NMI;
      else if (db) pick = SRC_DEBUG;
      else if (pf) pick = SRC_PAGEF;
      else if (it) pick = SRC_MASKABLE_IRQ_REQUEST;
      else if (sc) pick = SRC_STOPCLK;
      else         pick = SRC_NONE;
   endfunction : pick

   wire mc_req  = mc_pend_q & mce_en;
   wire ext_ok  = ~mc_block;
   ipx_src_t winner;
   assign winner = pick(mc_req & ext_ok, flush_s & ext_ok, smi_s & ext_ok, nmi_s & ext_ok,
                        dbg_pend_q | bp_pend_q, pf_pend_q, maskable_irq_request_s & if_en & ext_ok,
                        stopclk_s & ext_ok);
   // internal exceptions still reach the machine-check handler; pins are held off by ext_ok
   wire take = INSN_BOUNDARY_IN & (state_q != ST_ENTER) & (winner != SRC_NONE);

   function automatic logic [7:0] vec_of(input ipx_src_t s, input logic seg_ok);
      unique case (s)
         SRC_MCHECK:  vec_of = VEC_MCHECK;
         SRC_NMI:     vec_of = VEC_NMI;
         SRC_DEBUG:   vec_of = seg_ok ? VEC_DEBUG : VEC_NOTPRES;
         SRC_PAGEF:   vec_of = VEC_PAGEF;
         default:     vec_of = VEC_NONE;
      endcase
   endfunction : vec_of

   // ****************************************
   // apb decode
   // ****************************************
   wire acc     = PSEL & PENABLE;
   wire wr      = acc & PWRITE;
   wire wr_ctrl = wr & (PADDR == IPX_CTRL_OFS);
   wire wr_en   = wr & (PADDR == IPX_IRQ_EN_OFS);
   wire wr_clr  = wr & (PADDR == IPX_IRQ_CLR_OFS);
   wire wr_dst  = wr & (PADDR == IPX_DSTAT_OFS);
   wire mapped  = (PADDR[1:0] == 2'b00) & (PADDR <= IPX_STATUS_OFS);
   logic [31:0] rd_mux;
   always_comb begin
      unique case (PADDR)
         IPX_CTRL_OFS:     rd_mux = ctrl_q;
         IPX_DSTAT_OFS:    rd_mux = {{(32-NUM_BP){1'b0}}, dstat_q};
         IPX_SVC_OFS:      rd_mux = {20'h0_0000, src_q, SERVICE_VECTOR_OUT};
         IPX_SAVEIP_OFS:   rd_mux = save_ip_q;
         IPX_IRQ_STAT_OFS: rd_mux = {28'h000_0000, irq_stat_q};
         IPX_IRQ_EN_OFS:   rd_mux = {28'h000_0000, irq_en_q};
         IPX_STATUS_OFS:   rd_mux = {26'h000_0000, pins_s};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // pending events and debug capture
   // ****************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         mc_pend_q <= 1'b0;
         dbg_pend_q <= 1'b0;
         bp_pend_q <= 1'b0;
         pf_pend_q <= 1'b0;
         bp_temp_q <= '0;
         dstat_q   <= '0;
      end else begin
         mc_pend_q <= bus_check_s | (mc_pend_q & ~(take & winner == SRC_MCHECK));
         dbg_pend_q <= dbg_raise | (dbg_pend_q & ~(take & winner == SRC_DEBUG));
         bp_pend_q <= (|BP_MATCH_IN) | (bp_pend_q & ~(take & winner == SRC_DEBUG));
         pf_pend_q <= VERIFY_PAGE_FAULT_IN | (pf_pend_q & ~(take & winner == SRC_PAGEF));
         // temp holds every match, enabled or not; stop-clock never drops it
         bp_temp_q <= BP_MATCH_IN | (bp_temp_q & ~{NUM_BP{take & winner == SRC_DEBUG}});
         if (take && winner == SRC_DEBUG)
            dstat_q <= dstat_q | bp_temp_q | BP_MATCH_IN;
         else if (wr_dst)
            dstat_q <= PWDATA[NUM_BP-1:0];
      end
   end

   // ****************************************
   // service sequencing
   // ****************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         state_q            <= ST_RUN;
         src_q              <= SRC_NONE;
         SERVICE_VALID_OUT  <= 1'b0;
         SERVICE_VECTOR_OUT <= VEC_NONE;
         SERVICE_SOURCE_OUT <= 4'h0;
         io_ip_q            <= 32'h0000_0000;
         io_ip_vld_q        <= 1'b0;
         save_ip_q          <= 32'h0000_0000;
      end else begin
         SERVICE_VALID_OUT <= take;
         if (IO_RESTART_EVENT_IN && !io_ip_vld_q) begin
            io_ip_q     <= CUR_IP_IN;
            io_ip_vld_q <= 1'b1;
         end
         if (take) begin
            src_q              <= winner;
            SERVICE_VECTOR_OUT <= vec_of(winner, DEBUG_SEG_PRESENT_IN);
            SERVICE_SOURCE_OUT <= winner;
            if (winner == SRC_SMI) begin
               save_ip_q   <= (io_rst_en && io_ip_vld_q) ? io_ip_q : CUR_IP_IN;
               io_ip_vld_q <= 1'b0;
            end
         end
         unique case (state_q)
            ST_RUN: if (take) state_q <= (winner == SRC_MCHECK) ? ST_MC_HANDLER : ST_ENTER;
            ST_ENTER: state_q <= ST_RUN;
            ST_MC_HANDLER: if (wr_ctrl && PWDATA[CTRL_MC_DONE_BIT]) state_q <= ST_RUN;
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // ****************************************
   // control, interrupt regs, apb answer
   // ****************************************
   wire [IRQ_BITS-1:0] irq_ev = {take & winner == SRC_STOPCLK, take & winner == SRC_SMI,
                                 take & winner == SRC_DEBUG, take & winner == SRC_MCHECK};
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         ctrl_q     <= CTRL_RESET;
         irq_stat_q <= '0;
         irq_en_q   <= '0;
         IRQ_OUT    <= 1'b0;
         PRDATA     <= 32'h0000_0000;
         PREADY     <= 1'b0;
         PSLVERR    <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_q <= {29'h0000_0000, PWDATA[2:0]};
         if (wr_en) irq_en_q <= PWDATA[IRQ_BITS-1:0];
         // a new event wins over a same-cycle clear
         irq_stat_q <= irq_ev | (irq_stat_q & ~(wr_clr ? PWDATA[IRQ_BITS-1:0] : '0));
         IRQ_OUT    <= |(irq_stat_q & irq_en_q);
         PREADY     <= PSEL & ~PENABLE;
         PSLVERR    <= PSEL & ~PENABLE & ~mapped;
         PRDATA     <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : PRDATA;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   mc_first_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && mc_req && ext_ok |=> SERVICE_VECTOR_OUT == VEC_MCHECK)
      else $error("machine check not served first");
   mc_block_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      state_q == ST_MC_HANDLER |-> !(take && winner != SRC_DEBUG && winner != SRC_PAGEF))
      else $error("external request taken in machine check handler");
   maskable_irq_request_low_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && winner == SRC_MASKABLE_IRQ_REQUEST |-> !(nmi_s || smi_s || flush_s))
      else $error("maskable taken over higher source");
   stop_low_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && winner == SRC_STOPCLK |-> !(maskable_irq_request_s && if_en))
      else $error("stop clock taken over maskable");
   no_badop_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && mc_req && smi_s && dbg_pend_q && io_rst_en && ext_ok |=> SERVICE_SOURCE_OUT == SRC_MCHECK)
      else $error("machine check displaced");
   trap_dbg_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      TASK_SWITCH_DONE_IN && TSS_TRAP_BIT_IN |=> dbg_pend_q)
      else $error("trap bit did not raise debug");
   np_seg_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && winner == SRC_DEBUG && !DEBUG_SEG_PRESENT_IN |=> SERVICE_VECTOR_OUT == VEC_NOTPRES)
      else $error("not present handler not escalated");
   bp_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && winner == SRC_DEBUG |=> (dstat_q & $past(bp_temp_q)) == $past(bp_temp_q))
      else $error("matched breakpoint lost");
   smi_ip_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      take && winner == SRC_SMI && io_rst_en && io_ip_vld_q |=> save_ip_q == $past(io_ip_q))
      else $error("saved ip not io instruction");

endmodule : ipx_unit

// ==== bench/ipx_sys_model.sv ====
// behavioural system logic that drives the external request pins
module ipx_sys_model (
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   input  wire logic [5:0] want_in,
   output logic            bus_check_n_out,
   output logic            flush_n_out,
   output logic            mgmt_n_out,
   output logic            nmi_out,
   output logic            mask_rq_out,
   output logic            stop_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] want_q;
   logic [5:0] act;
   // slow mode answers a cycle late, like glue logic behind a register stage
   assign act = slow_in ? want_q : want_in;
   // pins rest inactive from time zero, active-low ones high
   initial {bus_check_n_out, flush_n_out, mgmt_n_out, nmi_out, mask_rq_out, stop_n_out} = 6'h39;
   always @(posedge clk_in) begin
      want_q <= want_in;
      bus_check_n_out <= ~act[0];
      flush_n_out <= ~act[1];
      mgmt_n_out <= ~act[2];
      nmi_out <= act[3];
      mask_rq_out <= act[4];
      stop_n_out <= ~act[5];
   end
endmodule : ipx_sys_model

// ==== bench/ipx_unit_bench.sv ====
// self-checking bench for the interrupt priority exception unit
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH at %0t: got %0h expected %0h", $time, (a), (b)); end end
module ipx_unit_bench import ipx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, bnd = 1'b0, iore = 1'b0, sstep = 1'b0, slow = 1'b0;
   logic        tsd = 1'b0, trap = 1'b0, segp = 1'b1, vpf = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  paddr = 8'h00, svec;
   logic [31:0] pwd = 32'h0, ip = 32'h0, ip0, prd;
   logic [3:0]  bp = 4'h0, ssrc;
   logic [5:0]  want = 6'h00;
   logic        bus_n, flush_n, mgmt_n, nmi_rq, mask_rq, stop_n, prdy, perr, sv, irq;
   logic [11:0] svc_q[$];
   logic [32:0] rd_q[$];
   logic [17:0] ladder[4];
   int          n_mismatch = 0, checks_done = 0;
   integer      seed = 32'h6fa7;

   always #5 clk = ~clk;

   ipx_sys_model sys (.clk_in(clk), .slow_in(slow), .want_in(want), .bus_check_n_out(bus_n),
      .flush_n_out(flush_n), .mgmt_n_out(mgmt_n), .nmi_out(nmi_rq), .mask_rq_out(mask_rq), .stop_n_out(stop_n));

   ipx_unit dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .BUS_CHECK_REQUEST_N_IN(bus_n), .FLUSH_REQUEST_N_IN(flush_n),
      .SYSTEM_MGMT_IRQ_N_IN(mgmt_n), .NMI_REQUEST_IN(nmi_rq), .MASKABLE_IRQ_REQUEST_IN(mask_rq),
      .STOP_CLOCK_REQUEST_N_IN(stop_n), .INSN_BOUNDARY_IN(bnd), .CUR_IP_IN(ip), .IO_RESTART_EVENT_IN(iore),
      .SINGLE_STEP_IN(sstep), .TASK_SWITCH_DONE_IN(tsd), .TSS_TRAP_BIT_IN(trap), .DEBUG_SEG_PRESENT_IN(segp),
      .VERIFY_PAGE_FAULT_IN(vpf), .BP_MATCH_IN(bp), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SERVICE_VALID_OUT(sv),
      .SERVICE_VECTOR_OUT(svec), .SERVICE_SOURCE_OUT(ssrc), .IRQ_OUT(irq));

   // ****************************************
   // bus cycles and stimulus tasks
   // ****************************************
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (prdy !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // zero means no service may follow this boundary
   task automatic serve(input logic [11:0] e);
      if (e !== 12'h000) svc_q.push_back(e);
      bnd <= 1'b1;
      @(posedge clk);
      bnd <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : serve

   task automatic settle();
      repeat (5) @(posedge clk);
   endtask : settle

   // ****************************************
   // result watchers and main sequence
   // ****************************************
   always @(posedge clk) begin
      if (sv === 1'b1) begin
         if (svc_q.size() == 0) `CHK(ssrc, 4'h0)
         else `CHK({ssrc, svec}, svc_q.pop_front())
      end
      if (psel && pen && prdy === 1'b1 && !pwr) `CHK({perr, prd}, rd_q.pop_front())
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      ladder = '{{6'h02, SRC_FLUSH, VEC_NONE}, {6'h04, SRC_SMI, VEC_NONE},
                 {6'h08, SRC_NMI, VEC_NMI}, {6'h10, SRC_MASKABLE_IRQ_REQUEST, VEC_NONE}};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK({sv, svec}, {1'b0, VEC_NONE})
      rd(IPX_CTRL_OFS, {1'b0, CTRL_RESET});
      rd(IPX_STATUS_OFS, {1'b0, 32'h0000_0027});
      rd(8'h20, {1'b1, 32'h0});
      apb(1'b1, IPX_CTRL_OFS, 32'h7);
      apb(1'b1, IPX_IRQ_EN_OFS, 32'h1);
      ip0 = $random(seed);
      ip <= ip0;
      iore <= 1'b1;
      sstep <= 1'b1;
      bp <= 4'hA;
      want <= 6'h3F;
      slow <= 1'b1;
      @(posedge clk);
      // short bus-check pulse: a held pin would re-arm the sticky pending bit after service
      want[0] <= 1'b0;
      iore <= 1'b0;
      sstep <= 1'b0;
      bp <= 4'h0;
      ip <= $random(seed);
      settle();
      serve({SRC_MCHECK, VEC_MCHECK});
      `CHK(irq, 1'b1)
      rd(IPX_IRQ_STAT_OFS, {1'b0, 32'h1});
      settle();
      // pins are blocked inside the handler, the internal debug event is not
      serve({SRC_DEBUG, VEC_DEBUG});
      apb(1'b1, IPX_CTRL_OFS, 32'hF);
      apb(1'b1, IPX_IRQ_CLR_OFS, 32'h1);
      // the interrupt line follows the cleared status one edge later
      @(posedge clk);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 4; i++) begin
         serve(ladder[i][11:0]);
         want <= want & ~ladder[i][17:12];
         settle();
      end
      serve({SRC_STOPCLK, VEC_NONE});
      `CHK(irq, 1'b0)
      rd(IPX_IRQ_STAT_OFS, {1'b0, 32'hE});
      rd(IPX_SAVEIP_OFS, {1'b0, ip0});
      rd(IPX_DSTAT_OFS, {1'b0, 32'hA});
      vpf <= 1'b1;
      tsd <= 1'b1;
      segp <= 1'b0;
      @(posedge clk);
      vpf <= 1'b0;
      tsd <= 1'b0;
      settle();
      serve({SRC_PAGEF, VEC_PAGEF});
      trap <= 1'b1;
      tsd <= 1'b1;
      @(posedge clk);
      tsd <= 1'b0;
      settle();
      serve({SRC_DEBUG, VEC_NOTPRES});
      segp <= 1'b1;
      tsd <= 1'b1;
      @(posedge clk);
      tsd <= 1'b0;
      trap <= 1'b0;
      settle();
      serve({SRC_DEBUG, VEC_DEBUG});
      rd(IPX_SVC_OFS, {1'b0, 20'h0_0000, SRC_DEBUG, VEC_DEBUG});
      `CHK(svc_q.size(), 0)
      close_out();
   end
endmodule : ipx_unit_bench
